/* ifpch_pkg.sv */
// constants for the ide function configuration header
`default_nettype none
package ifpch_pkg;

  // ==========================================================
  // configuration byte offsets
  localparam logic [7:0]  OFS_COMMAND  = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h06;
  localparam logic [7:0]  OFS_REVISION = 8'h08;
  localparam logic [7:0]  OFS_CLASS    = 8'h09;
  localparam logic [7:0]  OFS_MLT      = 8'h0D;
  localparam logic [7:0]  OFS_HEADER   = 8'h0E;

  // ==========================================================
  // dword indexes seen on the configuration port
  localparam logic [5:0]  DW_CMD_STS   = OFS_COMMAND[7:2];
  localparam logic [5:0]  DW_REV_CLASS = OFS_REVISION[7:2];
  localparam logic [5:0]  DW_MLT_HDR   = OFS_MLT[7:2];

  // ==========================================================
  // command register fields
  localparam int          CMD_IO_BIT   = 0;
  localparam int          CMD_MEM_BIT  = 1;
  localparam int          CMD_BM_BIT   = 2;
  localparam logic [15:0] CMD_RESET    = 16'h0000;

  // ==========================================================
  // status register fields
  localparam int          STS_STA_BIT  = 11;
  localparam int          STS_RTA_BIT  = 12;
  localparam int          STS_MAS_BIT  = 13;
  localparam logic [15:0] STS_FIXED    = 16'h0280;
  localparam logic [15:0] STS_RESET    = 16'h0280;
  localparam int          NUM_FLAGS    = 3;

  // ==========================================================
  // identity, latency timer and header values
  localparam logic [23:0] CLASS_CODE   = 24'h01_0180;
  localparam logic [3:0]  MLT_RESET    = 4'h0;
  localparam int          MLT_LSB      = 4;
  localparam logic [7:0]  HEADER_TYPE  = 8'h00;

endpackage : ifpch_pkg
`default_nettype wire

/* ifpch_burst_if.sv */
// link between the header registers and the burst latency timer
`default_nettype none
interface ifpch_burst_if;
  logic [3:0] slice;
  logic       frame_active;
  logic       hold_ack_n;
  logic       expired;
  logic       terminate;

  modport ctl   (output slice, output frame_active, output hold_ack_n,
                 input expired, input terminate);
  modport timer (input slice, input frame_active, input hold_ack_n,
                 output expired, output terminate);
endinterface : ifpch_burst_if
`default_nettype wire

/* ifpch_abort_flags.sv */
// sticky abort flags, set by events and cleared by write of one
`default_nettype none
module ifpch_abort_flags
  import ifpch_pkg::*;
#(
  parameter int N = NUM_FLAGS
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // events and clears
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  // flag state
  output logic      [N-1:0] flags_o
);

  // ==========================================================
  // one sticky bit per event; a set in the clear cycle wins
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      logic flag_reg;
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          flag_reg <= 1'b0;
        end else if (set_i[g]) begin
          flag_reg <= 1'b1;
        end else if (clr_i[g]) begin
          flag_reg <= 1'b0;
        end
      end
      assign flags_o[g] = flag_reg;
    end
  endgenerate

endmodule : ifpch_abort_flags
`default_nettype wire

/* ifpch_latency_timer.sv */
// burst latency counter for the bus-master engine
`default_nettype none
module ifpch_latency_timer
  import ifpch_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic      sys_clk_i,
  input  wire logic      rst_i,
  // link to the header registers
  ifpch_burst_if.timer   bus
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] limit;

  // programmed slice, low four bits taken as zero
  assign limit = CNT_W'({bus.slice, 4'h0});

  // ==========================================================
  // counter cleared while frame is idle, otherwise counts clocks up to the limit and holds there
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (!bus.frame_active) begin
      count_reg <= '0;
    end else if (count_reg < limit) begin
      count_reg <= count_reg + CNT_W'(1);
    end
  end

  // expiry matters only during a frame; ended frames ignore it
  assign bus.expired   = bus.frame_active && (count_reg >= limit);
  // terminate once expired and hold acknowledge removed
  assign bus.terminate = bus.expired && bus.hold_ack_n;

endmodule : ifpch_latency_timer
`default_nettype wire

/* ide_function_pci_config_header.sv */
// configuration header of the ide function, reached by config cycles
`default_nettype none

module ide_function_pci_config_header
  import ifpch_pkg::*;
#(
  // stepping byte; default value is arbitrary
  parameter logic [7:0] REVISION_ID = 8'h00,
  parameter int         LAT_CNT_W   = 8
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // configuration cycle port, function 1 already selected
  input  wire logic        cfg_sel_i,
  input  wire logic        cfg_rd_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [5:0]  cfg_dword_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_ack_o,
  // io decode hits from the address comparators
  input  wire logic        legacy_pri_hit_i,
  input  wire logic        legacy_sec_hit_i,
  input  wire logic        bm_regs_hit_i,
  output logic             legacy_pri_claim_o,
  output logic             legacy_sec_claim_o,
  output logic             bm_regs_claim_o,
  // bus-master engine
  output logic             bus_master_enable_o,
  input  wire logic        frame_driven_i,
  input  wire logic        hold_ack_n_i,
  output logic             burst_terminate_o,
  output logic             latency_expired_o,
  // abort events, one-cycle pulses
  input  wire logic        master_abort_i,
  input  wire logic        target_abort_rcvd_i,
  input  wire logic        target_abort_sig_i
);

  // ==========================================================
  // declarations
  logic                 io_space_enable_reg;
  logic                 bus_master_enable_reg;
  logic [3:0]           mlt_slice_reg;
  logic                 wr_take;
  logic                 rd_take;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] flags;
  logic [15:0]          command_val;
  logic [15:0]          status_val;
  logic [7:0]           mlt_val;
  logic [31:0]          rdata_next;
  logic [31:0]          cfg_rdata_reg;
  logic                 cfg_ack_reg;

  ifpch_burst_if burst ();

  // ==========================================================
  // helper: byte lane select for a dword write
  function automatic logic lane_wr(input logic       take,
                                   input logic [5:0] dw,
                                   input logic [5:0] target,
                                   input logic [3:0] be,
                                   input int         lane);
    lane_wr = take && (dw == target) && be[lane];
  endfunction : lane_wr

  // requests are taken in the cycle they are presented
  assign wr_take = cfg_sel_i && cfg_wr_i;
  assign rd_take = cfg_sel_i && cfg_rd_i && !cfg_wr_i;

  // ==========================================================
  // command register: only io and bus-master enables are stored
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_space_enable_reg   <= CMD_RESET[CMD_IO_BIT];
      bus_master_enable_reg <= CMD_RESET[CMD_BM_BIT];
    end else if (lane_wr(wr_take, cfg_dword_i, DW_CMD_STS, cfg_be_i, 0)) begin
      io_space_enable_reg   <= cfg_wdata_i[CMD_IO_BIT];
      bus_master_enable_reg <= cfg_wdata_i[CMD_BM_BIT];
    end
  end

  // fixed bits read as constants, all others zero
  always_comb begin
    command_val              = 16'h0000;
    command_val[CMD_IO_BIT]  = io_space_enable_reg;
    command_val[CMD_MEM_BIT] = 1'b1;
    command_val[CMD_BM_BIT]  = bus_master_enable_reg;
  end

  // ==========================================================
  // status flags: events set, write of one in lane 3 clears
  assign flag_set = {master_abort_i,
                     target_abort_rcvd_i,
                     target_abort_sig_i};

  // write-one-to-clear; zeros leave the flags alone
  always_comb begin
    flag_clr = '0;
    if (lane_wr(wr_take, cfg_dword_i, DW_CMD_STS, cfg_be_i, 3)) begin
      flag_clr = {cfg_wdata_i[16+STS_MAS_BIT],
                  cfg_wdata_i[16+STS_RTA_BIT],
                  cfg_wdata_i[16+STS_STA_BIT]};
    end
  end

  ifpch_abort_flags #(
    .N         (NUM_FLAGS)
  ) u_flags (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .set_i     (flag_set),
    .clr_i     (flag_clr),
    .flags_o   (flags)
  );

  // fixed timing and fast back-to-back bits over the sticky flags
  always_comb begin
    status_val              = STS_FIXED;
    status_val[STS_MAS_BIT] = flags[2];
    status_val[STS_RTA_BIT] = flags[1];
    status_val[STS_STA_BIT] = flags[0];
  end

  // ==========================================================
  // latency timer setting: upper nibble stored, lower reads zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mlt_slice_reg <= MLT_RESET;
    end else if (lane_wr(wr_take, cfg_dword_i, DW_MLT_HDR, cfg_be_i, 1)) begin
      mlt_slice_reg <= cfg_wdata_i[8+MLT_LSB +: 4];
    end
  end

  assign mlt_val = {mlt_slice_reg, 4'h0};

  // ==========================================================
  // burst latency timer
  assign burst.slice        = mlt_slice_reg;
  // count only frames that the enabled master engine drives
  assign burst.frame_active = frame_driven_i && bus_master_enable_reg;
  assign burst.hold_ack_n   = hold_ack_n_i;

  ifpch_latency_timer #(
    .CNT_W     (LAT_CNT_W)
  ) u_latency (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bus       (burst)
  );

  assign burst_terminate_o = burst.terminate;
  assign latency_expired_o = burst.expired;

  // ==========================================================
  // io decode gating and engine enable
  assign legacy_pri_claim_o  = io_space_enable_reg && legacy_pri_hit_i;
  assign legacy_sec_claim_o  = io_space_enable_reg && legacy_sec_hit_i;
  assign bm_regs_claim_o     = io_space_enable_reg && bm_regs_hit_i;
  assign bus_master_enable_o = bus_master_enable_reg;

  // ==========================================================
  // read multiplexer; unmapped dwords read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (cfg_dword_i)
      DW_CMD_STS: begin
        rdata_next = {status_val, command_val};
      end
      DW_REV_CLASS: begin
        rdata_next = {CLASS_CODE, REVISION_ID};
      end
      DW_MLT_HDR: begin
        rdata_next = {8'h00, HEADER_TYPE, mlt_val, 8'h00};
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================
  // read data and acknowledge one cycle after the request
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      cfg_rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ack_reg <= 1'b0;
    end else begin
      cfg_ack_reg <= rd_take || wr_take;
    end
  end

  assign cfg_rdata_o = cfg_rdata_reg;
  assign cfg_ack_o   = cfg_ack_reg;

endmodule : ide_function_pci_config_header
`default_nettype wire

/* ifpch_unused_guard.sv */
// spare unit for shared design helpers; holds no code
`default_nettype none
`default_nettype wire

/* ifpch_props.sv */
// port assertions for the ide function configuration header
`default_nettype none
module ifpch_props
  import ifpch_pkg::*;
(
  // clock, reset and configuration port
  input wire logic        sys_clk_i, rst_i, cfg_sel_i, cfg_rd_i, cfg_wr_i,
  input wire logic [5:0]  cfg_dword_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_ack_o,
  // decode, bus-master engine
  input wire logic        legacy_pri_hit_i, legacy_sec_hit_i, bm_regs_hit_i,
  input wire logic        legacy_pri_claim_o, legacy_sec_claim_o,
  input wire logic        bm_regs_claim_o, bus_master_enable_o,
  input wire logic        frame_driven_i, hold_ack_n_i,
  input wire logic        burst_terminate_o, latency_expired_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic rd_only;
  // taken request and pure read
  assign req     = cfg_sel_i & (cfg_rd_i | cfg_wr_i);
  assign rd_only = cfg_sel_i & cfg_rd_i & ~cfg_wr_i;
  ack_follows_req_a: assert property (req |=> cfg_ack_o)
    else $error("no ack after request");
  ack_needs_req_a: assert property (cfg_ack_o |-> $past(req))
    else $error("ack without request");
  cmd_sts_fixed_a: assert property (
    rd_only && cfg_dword_i == DW_CMD_STS
    |=> (cfg_rdata_o & 32'hC7FF_FFFA) == 32'h0280_0002)
    else $error("fixed command or status bits wrong");
  class_read_a: assert property (rd_only && cfg_dword_i == DW_REV_CLASS
    |=> cfg_rdata_o[31:8] == CLASS_CODE) else $error("class code wrong");
  header_read_a: assert property (
    rd_only && cfg_dword_i == DW_MLT_HDR
    |=> (cfg_rdata_o & 32'hFFFF_0FFF) == 32'h0000_0000)
    else $error("header or timer low bits wrong");
  claim_gate_a: assert property (
    !((legacy_pri_claim_o & !legacy_pri_hit_i)
    | (legacy_sec_claim_o & !legacy_sec_hit_i)
    | (bm_regs_claim_o & !bm_regs_hit_i)))
    else $error("claim without hit");
  claim_agree_a: assert property (legacy_pri_hit_i && bm_regs_hit_i
    |-> legacy_pri_claim_o == bm_regs_claim_o) else $error("claims differ");
  bm_enable_held_a: assert property (!(req && cfg_wr_i)
    |=> $stable(bus_master_enable_o))
    else $error("enable moved without write");
  term_cause_a: assert property (burst_terminate_o
    |-> latency_expired_o && hold_ack_n_i)
    else $error("terminate without cause");
  expiry_frame_a: assert property (
    !frame_driven_i |-> !latency_expired_o)
    else $error("expired outside frame");
endmodule : ifpch_props
bind ide_function_pci_config_header ifpch_props props_u (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_sel_i(cfg_sel_i),
  .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .cfg_dword_i(cfg_dword_i),
  .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
  .legacy_pri_hit_i(legacy_pri_hit_i), .legacy_sec_hit_i(legacy_sec_hit_i),
  .bm_regs_hit_i(bm_regs_hit_i), .legacy_pri_claim_o(legacy_pri_claim_o),
  .legacy_sec_claim_o(legacy_sec_claim_o), .bm_regs_claim_o(bm_regs_claim_o),
  .bus_master_enable_o(bus_master_enable_o), .frame_driven_i(frame_driven_i),
  .hold_ack_n_i(hold_ack_n_i), .burst_terminate_o(burst_terminate_o),
  .latency_expired_o(latency_expired_o));
`default_nettype wire

/* ifpch_host_model.sv */
// configuration master model driving the header's config port
`default_nettype none
module ifpch_host_model (
  // clock and answer
  input  wire logic        sys_clk_i,
  input  wire logic        cfg_ack_i,
  input  wire logic [31:0] cfg_rdata_i,
  // request
  output var logic         cfg_sel_o, cfg_rd_o, cfg_wr_o,
  output var logic  [5:0]  cfg_dword_o,
  output var logic  [3:0]  cfg_be_o,
  output var logic  [31:0] cfg_wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {cfg_sel_o, cfg_rd_o, cfg_wr_o} = 3'b000;
    cfg_dword_o = 6'h00;
    cfg_be_o    = 4'h0;
    cfg_wdata_o = 32'h0000_0000;
  end
  // one-cycle request, then wait a bounded time for the ack
  task automatic xfer(input logic w, input logic [5:0] dw,
                      input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(posedge sys_clk_i);
    #1;
    {cfg_sel_o, cfg_wr_o, cfg_rd_o} = {1'b1, w, !w};
    cfg_dword_o = dw;
    cfg_be_o    = be;
    cfg_wdata_o = d;
    @(posedge sys_clk_i);
    #1;
    {cfg_sel_o, cfg_wr_o, cfg_rd_o} = 3'b000;
    cfg_wdata_o = ~d; // released lines do not keep the old value
    cfg_be_o    = ~be;
    ok = 1'b0;
    q  = 32'h0000_0000;
    // ack and read data are looked at off the edge, while they stand
    for (n = 0; n < 4 && !ok; n++) begin
      if (cfg_ack_i === 1'b1) begin
        ok = 1'b1;
        q  = cfg_rdata_i;
      end else begin
        @(posedge sys_clk_i);
        #1;
      end
    end
  endtask : xfer
endmodule : ifpch_host_model
`default_nettype wire

/* ide_function_pci_config_header_tb_top.sv */
// self-checking bench for the ide function configuration header
`default_nettype none
module ide_function_pci_config_header_tb_top;
  import ifpch_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] REV = 8'h5A; // arbitrary stepping value
  logic sys_clk_i = 1'b0, rst_i = 1'b1, sel, rd, wr, ack, bus_master_enable, fr = 1'b0;
  logic hold_n = 1'b0, term, expd;
  logic [5:0]  dw;
  logic [3:0]  be;
  logic [31:0] wd, rdat;
  logic [2:0]  hit = 3'b000, claim, ab = 3'b000;
  int n_fail = 0, comparisons = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  ide_function_pci_config_header #(.REVISION_ID(REV), .LAT_CNT_W(8)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_sel_i(sel), .cfg_rd_i(rd),
    .cfg_wr_i(wr), .cfg_dword_i(dw), .cfg_be_i(be), .cfg_wdata_i(wd),
    .cfg_rdata_o(rdat), .cfg_ack_o(ack), .legacy_pri_hit_i(hit[0]),
    .legacy_sec_hit_i(hit[1]), .bm_regs_hit_i(hit[2]),
    .legacy_pri_claim_o(claim[0]), .legacy_sec_claim_o(claim[1]),
    .bm_regs_claim_o(claim[2]), .bus_master_enable_o(bus_master_enable),
    .frame_driven_i(fr), .hold_ack_n_i(hold_n), .burst_terminate_o(term),
    .latency_expired_o(expd), .master_abort_i(ab[2]),
    .target_abort_rcvd_i(ab[1]), .target_abort_sig_i(ab[0]));
  ifpch_host_model host_u (.sys_clk_i(sys_clk_i), .cfg_ack_i(ack),
    .cfg_rdata_i(rdat), .cfg_sel_o(sel), .cfg_rd_o(rd), .cfg_wr_o(wr),
    .cfg_dword_o(dw), .cfg_be_o(be), .cfg_wdata_o(wd));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [5:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    logic [31:0] q;
    logic ok;
    host_u.xfer(w, a, b, d, q, ok);
    if (!ok) begin
      n_fail++;
      close_out();
    end
    if (!w) chk(q, d);
  endtask : acc
  // reset values of every register
  task automatic t_defaults;
    acc(0, 6'd1, 4'h0, 32'h0280_0002);
    acc(0, 6'd2, 4'h0, {CLASS_CODE, REV});
    acc(0, 6'd3, 4'h0, 32'h0000_0000);
    acc(0, 6'd7, 4'h0, 32'h0000_0000);
  endtask : t_defaults
  // command bits, enables and io decode gating
  task automatic t_command;
    hit = 3'b111;
    acc(1, 6'd1, 4'hF, 32'hFFFF_FFFF);
    acc(0, 6'd1, 4'h0, 32'h0280_0007);
    chk({29'd0, claim}, 32'd7);
    chk({31'd0, bus_master_enable}, 32'd1);
    acc(1, 6'd1, 4'hE, 32'h0000_0000);
    acc(0, 6'd1, 4'h0, 32'h0280_0007);
    acc(1, 6'd1, 4'h1, 32'h0000_0000);
    chk({28'd0, bus_master_enable, claim}, 32'd0);
  endtask : t_command
  // abort flags set by events and cleared by writing one
  task automatic t_flags;
    @(posedge sys_clk_i);
    #1 ab = 3'b111;
    @(posedge sys_clk_i);
    #1 ab = 3'b000;
    acc(0, 6'd1, 4'h0, 32'h3A80_0002);
    acc(1, 6'd1, 4'h6, 32'hFFFF_FFFC);
    acc(1, 6'd1, 4'h8, 32'h0000_0000);
    acc(0, 6'd1, 4'h0, 32'h3A80_0002);
    acc(1, 6'd1, 4'h8, 32'h1000_0000);
    acc(0, 6'd1, 4'h0, 32'h2A80_0002);
    acc(1, 6'd1, 4'h8, 32'h2800_0000);
    acc(0, 6'd1, 4'h0, 32'h0280_0002);
    // abort event in the very cycle of its clear: the event wins
    fork
      acc(1, 6'd1, 4'h8, 32'h2000_0000);
      begin
        @(posedge sys_clk_i);
        #1 ab = 3'b100;
        @(posedge sys_clk_i);
        #1 ab = 3'b000;
      end
    join
    acc(0, 6'd1, 4'h0, 32'h2280_0002);
  endtask : t_flags
  // read-only bytes and timer setting lanes
  task automatic t_readonly;
    acc(1, 6'd2, 4'hF, 32'hFFFF_FFFF);
    acc(1, 6'd3, 4'hF, 32'hFFFF_FFFF);
    acc(0, 6'd2, 4'h0, {CLASS_CODE, REV});
    acc(0, 6'd3, 4'h0, 32'h0000_F000);
  endtask : t_readonly
  // burst slice of 48 clocks, then release of hold acknowledge
  task automatic t_latency;
    int n;
    acc(1, 6'd3, 4'h2, 32'h0000_3000);
    acc(1, 6'd1, 4'h1, 32'h0000_0004);
    @(posedge sys_clk_i);
    #1 fr = 1'b1;
    for (n = 1; n <= 100; n++) begin
      @(posedge sys_clk_i);
      #1;
      if (expd === 1'b1) break;
    end
    chk(32'(n), 32'd48);
    chk({31'd0, term}, 32'd0);
    @(posedge sys_clk_i);
    #1 hold_n = 1'b1;
    #1 chk({31'd0, term}, 32'd1);
    @(posedge sys_clk_i);
    #1 fr = 1'b0;
    @(posedge sys_clk_i);
    #1 chk({30'd0, expd, term}, 32'd0);
    fr = 1'b1; // a fresh frame starts from a cleared count
    @(posedge sys_clk_i);
    #1 chk({31'd0, expd}, 32'd0);
    fr = 1'b0;
  endtask : t_latency
  initial begin
    repeat (5) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    t_defaults();
    t_command();
    t_flags();
    t_readonly();
    t_latency();
    close_out();
  end
endmodule : ide_function_pci_config_header_tb_top
`default_nettype wire
